// ==== lfdc_pkg.sv ====
// Constants, register map, gamma table and bus carrier for the LED fade/dimming control.
// Assumes a 100 MHz hclk; all timing figures are derived from it here.
package lfdc_pkg;

  // ==========================================================================
  // Timing
  localparam int CYC_PER_US          = 100;
  localparam int DEBOUNCE_MS         = 37;
  localparam int DEBOUNCE_CYCLES     = DEBOUNCE_MS * 1000 * CYC_PER_US;
  localparam int INT_PWM_HZ          = 220;
  localparam int PWM_SCALE           = 1000;
  localparam int PWM_TICK_CYCLES     = (CYC_PER_US * 1000000) / (INT_PWM_HZ * PWM_SCALE);
  localparam int FADE_STEPS          = 63;
  localparam int LEVEL_MAX           = FADE_STEPS - 1;
  localparam int INSTANT_RAMP_US     = 70;
  localparam int INSTANT_STEP_CYCLES = (INSTANT_RAMP_US * CYC_PER_US) / FADE_STEPS;

  // ==========================================================================
  // Register map
  localparam logic [31:0] RISE_OFS    = 32'h0000_0000;
  localparam logic [31:0] FALL_OFS    = 32'h0000_0004;
  localparam logic [31:0] STAT_OFS    = 32'h0000_0008;
  localparam logic [15:0] STEP_US_RST = 16'h0f80;

  // Status field positions
  localparam int ST_LVL0    = 0;
  localparam int ST_LVL1    = 8;
  localparam int ST_EN_ON   = 16;
  localparam int ST_DIM_ON  = 18;
  localparam int ST_OUT     = 20;
  localparam int ST_SWITCH_LIGHT_OUTPUT    = 22;
  localparam int ST_PULSE   = 23;
  localparam int ST_EXT     = 24;
  localparam int ST_POL     = 25;
  localparam int ST_STRAPOK = 26;

  // ==========================================================================
  // Gamma curve, duty in units of 1/PWM_SCALE
  localparam logic [9:0] GAMMA [0:62] = '{
    10'd0,   10'd2,   10'd4,   10'd6,   10'd8,   10'd10,  10'd12,  10'd16,
    10'd20,  10'd24,  10'd28,  10'd32,  10'd36,  10'd42,  10'd48,  10'd54,
    10'd60,  10'd66,  10'd72,  10'd80,  10'd88,  10'd96,  10'd104, 10'd112,
    10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
    10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
    10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
    10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
    10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000};

  // ==========================================================================
  // AHB-Lite request carrier
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } lfdc_ahb_req_s;

endpackage

// ==== lfdc_top.sv ====
// Fade and dimming control for two main LED channels and one switch-light channel.
// Assumes synchronous pin inputs, static strap pins and a single AHB-Lite master.
//
// How it works
// - Each enable ramps own channel, 63 gamma steps
// - Toggling again mid-ramp reverses the ramp
// - Style strap high pulse-toggle, low level-follow
// - Debounced low pulse toggles channel on/off
// - All LED outputs start off after power-up
// - Level style: debounced high fades on
// - Level style: debounced low fades off
// - Rise and fall use separate step durations
// - Enables debounced 37ms on both edges
// - Switch light follows its enable directly
// - Switch light duty follows enable duty
// - Dimming input drives both main channels
// - Source strap high direct, low internal fade
// - Polarity strap selects dimming active level
// - Direct dimming bypasses gamma and ramps
// - Direct: leaving active turns off dim-on only
// - Internal: debounced dimming change fades both
// - Internal 220Hz PWM through gamma curve
// - Internal: leaving active fades dim-on only
// - Zero duration setting gives near-instant ramp
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module lfdc_top #(
  parameter int DEBOUNCE_CYCLES = lfdc_pkg::DEBOUNCE_CYCLES,
  parameter int PWM_TICK_CYCLES = lfdc_pkg::PWM_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  // AHB-Lite slave
  input  wire lfdc_pkg::lfdc_ahb_req_s ahb_req,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Control pins
  input  wire logic [1:0]            main_channel_enable,
  input  wire logic                  dimming_input,
  input  wire logic                  switch_light_enable,
  input  wire logic                  dimming_source_strap,
  input  wire logic                  enable_style_strap,
  input  wire logic                  dimming_polarity_strap,
  // Outputs
  output logic [1:0]                 main_led_outputs,
  output logic                       switch_light_output,
  output logic                       logic_supply_output
);

  // ==========================================================================
  // Parameter checks
  if (DEBOUNCE_CYCLES < 2 || DEBOUNCE_CYCLES >= (1 << 23)) begin : g_chk_deb
    $error("DEBOUNCE_CYCLES out of range");
  end
  if (PWM_TICK_CYCLES < 1 || PWM_TICK_CYCLES >= (1 << 20)) begin : g_chk_pwm
    $error("PWM_TICK_CYCLES out of range");
  end

  // ==========================================================================
  // Declarations
  logic        strap_ok;
  logic        pulse_mode;
  logic        ext_mode;
  logic        pol_high;
  logic [15:0] rise_duration_setting;
  logic [15:0] fall_duration_setting;
  logic [23:0] rise_cyc;
  logic [23:0] fall_cyc;
  logic [2:0]  db_raw;
  logic [2:0]  db_lvl;
  logic [2:0]  db_rise;
  logic [2:0]  db_fall;
  logic [22:0] db_cnt [0:2];
  logic        act_raw;
  logic        act_q;
  logic        dim_rise;
  logic        dim_fall;
  logic [1:0]  en_on;
  logic [1:0]  dim_on;
  logic [1:0]  next_en_on;
  logic [1:0]  next_dim_on;
  logic [5:0]  level [0:1];
  logic [23:0] ramp_cnt [0:1];
  logic [1:0]  step_done;
  logic [19:0] tick_cnt;
  logic [9:0]  pwm_phase;
  logic        dp_wr;
  logic [31:0] dp_addr;
  logic        ap_take;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  assign logic_supply_output = 1'b1;

  // ==========================================================================
  // Strap capture after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_ok   <= 1'b0;
      pulse_mode <= 1'b0;
      ext_mode   <= 1'b0;
      pol_high   <= 1'b0;
    end else if (ce && !strap_ok) begin
      strap_ok   <= 1'b1;
      pulse_mode <= enable_style_strap;
      ext_mode   <= dimming_source_strap;
      pol_high   <= dimming_polarity_strap;
    end
  end

  // ==========================================================================
  // Debouncers: two enables and the dimming active level
  assign act_raw = strap_ok && (dimming_input == pol_high);
  assign db_raw  = {act_raw, main_channel_enable};

  for (genvar k = 0; k < 3; k++) begin : g_deb
    logic fire;
    assign fire       = ce && (db_raw[k] != db_lvl[k]) && (db_cnt[k] == 23'(DEBOUNCE_CYCLES - 1));
    assign db_rise[k] = fire && db_raw[k];
    assign db_fall[k] = fire && !db_raw[k];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        db_lvl[k] <= 1'b0;
        db_cnt[k] <= '0;
      end else if (ce) begin
        if (db_raw[k] == db_lvl[k]) begin
          db_cnt[k] <= '0;
        end else if (fire) begin
          db_lvl[k] <= db_raw[k];
          db_cnt[k] <= '0;
        end else begin
          db_cnt[k] <= db_cnt[k] + 23'd1;
        end
      end
    end
    a_deb_settle: assert property ($changed(db_lvl[k]) |-> $past(db_cnt[k]) == 23'(DEBOUNCE_CYCLES - 1))
      else $error("debounced level changed before full interval");
  end

  // ==========================================================================
  // Dimming edges, direct or debounced
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
    end else if (ce) begin
      act_q <= act_raw;
    end
  end

  assign dim_rise = ext_mode ? (ce && act_raw && !act_q) : db_rise[2];
  assign dim_fall = ext_mode ? (ce && !act_raw && act_q) : db_fall[2];

  // ==========================================================================
  // Internal PWM time base
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt  <= '0;
      pwm_phase <= '0;
    end else if (ce) begin
      if (tick_cnt == 20'(PWM_TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
        if (pwm_phase == 10'(lfdc_pkg::PWM_SCALE - 1)) begin
          pwm_phase <= '0;
        end else begin
          pwm_phase <= pwm_phase + 10'd1;
        end
      end else begin
        tick_cnt <= tick_cnt + 20'd1;
      end
    end
  end

  // ==========================================================================
  // Ramp step durations
  assign rise_cyc = (rise_duration_setting == 16'h0000) ? 24'(lfdc_pkg::INSTANT_STEP_CYCLES)
                    : 24'(rise_duration_setting) * 24'(lfdc_pkg::CYC_PER_US);
  assign fall_cyc = (fall_duration_setting == 16'h0000) ? 24'(lfdc_pkg::INSTANT_STEP_CYCLES)
                    : 24'(fall_duration_setting) * 24'(lfdc_pkg::CYC_PER_US);

  // ==========================================================================
  // Main channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic       tgt_on;
    logic       goal_full;
    logic [5:0] goal;
    logic [23:0] step_cyc;

    assign tgt_on = en_on[i] || dim_on[i];

    // Channel state: dimming events first, enable events override
    always_comb begin
      next_en_on[i]  = en_on[i];
      next_dim_on[i] = dim_on[i];
      if (dim_rise && !tgt_on) begin
        next_dim_on[i] = 1'b1;
      end
      if (dim_fall || (ext_mode && !act_raw)) begin
        next_dim_on[i] = 1'b0;
      end
      if (pulse_mode) begin
        if (db_fall[i]) begin
          next_en_on[i]  = !tgt_on;
          next_dim_on[i] = 1'b0;
        end
      end else begin
        if (db_rise[i]) begin
          next_en_on[i] = 1'b1;
        end
        if (db_fall[i]) begin
          next_en_on[i]  = 1'b0;
          next_dim_on[i] = 1'b0;
        end
      end
      if (!strap_ok) begin
        next_en_on[i]  = 1'b0;
        next_dim_on[i] = 1'b0;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        en_on[i]  <= 1'b0;
        dim_on[i] <= 1'b0;
      end else if (ce) begin
        en_on[i]  <= next_en_on[i];
        dim_on[i] <= next_dim_on[i];
      end
    end

    // Ramp engine; reversal just changes the goal
    assign goal_full    = en_on[i] || (dim_on[i] && !ext_mode);
    assign goal         = goal_full ? 6'(lfdc_pkg::LEVEL_MAX) : 6'd0;
    assign step_cyc     = (goal > level[i]) ? rise_cyc : fall_cyc;
    assign step_done[i] = (level[i] != goal) && (ramp_cnt[i] >= step_cyc - 24'd1);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        level[i]    <= '0;
        ramp_cnt[i] <= '0;
      end else if (ce) begin
        if (level[i] == goal) begin
          ramp_cnt[i] <= '0;
        end else if (step_done[i]) begin
          ramp_cnt[i] <= '0;
          level[i]    <= (goal > level[i]) ? level[i] + 6'd1 : level[i] - 6'd1;
        end else begin
          ramp_cnt[i] <= ramp_cnt[i] + 24'd1;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        main_led_outputs[i] <= 1'b0;
      end else if (ce) begin
        main_led_outputs[i] <= (pwm_phase < lfdc_pkg::GAMMA[level[i]])
                               || (ext_mode && next_dim_on[i]);
      end
    end

    a_level_range: assert property (level[i] <= 6'(lfdc_pkg::LEVEL_MAX))
      else $error("fade level beyond last gamma step");
    a_level_step: assert property ($changed(level[i]) |-> $past(step_done[i]) && $past(ce))
      else $error("fade level moved without a step expiry");
    a_pulse_toggle: assert property (ce && pulse_mode && db_fall[i] && !tgt_on |=> en_on[i])
      else $error("pulse did not turn an off channel on");
    a_level_on: assert property (ce && !pulse_mode && db_rise[i] |=> en_on[i])
      else $error("level style rise did not turn channel on");
    a_level_off: assert property (ce && !pulse_mode && db_fall[i] |=> !en_on[i] && !dim_on[i])
      else $error("level style fall did not turn channel off");
    a_ext_leave: assert property (ce && strap_ok && ext_mode && !act_raw |=> !dim_on[i])
      else $error("direct dimming left active but channel stayed dim-on");
    a_ext_direct: assert property (ce && ext_mode && act_raw && dim_on[i] && !db_fall[i]
                                   && !(pulse_mode && db_fall[i]) |=> main_led_outputs[i])
      else $error("direct dimming active but output low");
  end

  a_fade_both: assert property (ce && strap_ok && !ext_mode && dim_rise && !en_on[0] && !dim_on[0]
                                && !en_on[1] && !dim_on[1] && db_fall[1:0] == 2'b00 && db_rise[1:0] == 2'b00
                                |=> dim_on == 2'b11)
    else $error("dimming event did not reach both channels");

  // ==========================================================================
  // Switch light channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_light_output <= 1'b0;
    end else if (ce) begin
      switch_light_output <= strap_ok && switch_light_enable;
    end
  end

  a_sw_follow: assert property (ce && strap_ok |=> switch_light_output == $past(switch_light_enable))
    else $error("switch light did not follow its enable");
  a_power_off: assert property (!strap_ok |-> main_led_outputs == 2'b00 && !switch_light_output)
    else $error("output on before start-up");

  // ==========================================================================
  // AHB-Lite slave: wait states only while ce is low, always OKAY
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign ap_take   = ce && ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= '0;
    end else if (ce) begin
      dp_wr   <= ap_take && ahb_req.hwrite;
      dp_addr <= ahb_req.haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_duration_setting <= lfdc_pkg::STEP_US_RST;
      fall_duration_setting <= lfdc_pkg::STEP_US_RST;
    end else if (ce && dp_wr) begin
      if (dp_addr == lfdc_pkg::RISE_OFS) begin
        rise_duration_setting <= ahb_req.hwdata[15:0];
      end
      if (dp_addr == lfdc_pkg::FALL_OFS) begin
        fall_duration_setting <= ahb_req.hwdata[15:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ce) begin
      hrdata <= '0;
      if (ap_take && !ahb_req.hwrite) begin
        case (ahb_req.haddr)
          lfdc_pkg::RISE_OFS: begin
            hrdata[15:0] <= (dp_wr && dp_addr == lfdc_pkg::RISE_OFS) ? ahb_req.hwdata[15:0]
                            : rise_duration_setting;
          end
          lfdc_pkg::FALL_OFS: begin
            hrdata[15:0] <= (dp_wr && dp_addr == lfdc_pkg::FALL_OFS) ? ahb_req.hwdata[15:0]
                            : fall_duration_setting;
          end
          lfdc_pkg::STAT_OFS: begin
            hrdata[lfdc_pkg::ST_LVL0 +: 6]  <= level[0];
            hrdata[lfdc_pkg::ST_LVL1 +: 6]  <= level[1];
            hrdata[lfdc_pkg::ST_EN_ON +: 2] <= en_on;
            hrdata[lfdc_pkg::ST_DIM_ON +: 2] <= dim_on;
            hrdata[lfdc_pkg::ST_OUT +: 2]   <= main_led_outputs;
            hrdata[lfdc_pkg::ST_SWITCH_LIGHT_OUTPUT]       <= switch_light_output;
            hrdata[lfdc_pkg::ST_PULSE]      <= pulse_mode;
            hrdata[lfdc_pkg::ST_EXT]        <= ext_mode;
            hrdata[lfdc_pkg::ST_POL]        <= pol_high;
            hrdata[lfdc_pkg::ST_STRAPOK]    <= strap_ok;
          end
          default: begin
            hrdata <= '0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Covers
  c_pulse_toggle: cover property (@(posedge hclk) disable iff (!hresetn) pulse_mode && db_fall[0]);
  c_reverse: cover property (@(posedge hclk) disable iff (!hresetn)
                             level[1] != 6'd0 && level[1] != 6'(lfdc_pkg::LEVEL_MAX) && db_fall[1]);
  c_ext_dim: cover property (@(posedge hclk) disable iff (!hresetn) ext_mode && dim_rise);
  c_int_fade: cover property (@(posedge hclk) disable iff (!hresetn) !ext_mode && db_rise[2]);

endmodule

// ==== lfdc_pin_driver.sv ====
// Far-side model: switches on the enable pins with contact bounce, clean dimming pin.
// Assumes the bench changes the wanted positions just after rising edges.
`timescale 1ns/10ps
module lfdc_pin_driver #(
  parameter int BOUNCE = 6
) (
  // Clock
  input  wire logic       hclk,
  // Wanted positions
  input  wire logic [1:0] en_target,
  input  wire logic       dim_target,
  // Pins
  output logic [1:0]      main_channel_enable,
  output logic            dimming_input
);
  logic [1:0] cur = 2'b00;
  logic [1:0] prev = 2'b00;
  int         cnt = 0;

  // ==========================================================================
  // Bounce
  // Contacts chatter between old and new level after each change
  always @(posedge hclk) begin
    if (en_target !== cur) begin
      prev <= cur;
      cur  <= en_target;
      cnt  <= BOUNCE;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign main_channel_enable = (cnt != 0 && cnt[1]) ? prev : cur;
  assign dimming_input       = dim_target;
endmodule

// ==== lfdc_top_test.sv ====
// Testbench for the LED fade and dimming control: bus, straps, fades, dimming.
// Assumes lfdc_pkg, lfdc_top and lfdc_pin_driver are compiled first.
`timescale 1ns/10ps
module lfdc_top_test;
  localparam int DEB   = 20;
  localparam int LIMIT = 90000;
  logic                   hclk = 1'b0;
  logic                   hresetn = 1'b0;
  logic                   ce_t = 1'b1;
  logic [1:0]             en_t = 2'b11;
  logic                   dim_t = 1'b0;
  logic                   sle = 1'b0;
  logic [2:0]             straps = 3'b011;
  lfdc_pkg::lfdc_ahb_req_s m = '0;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [1:0]             mlo;
  logic [1:0]             en_pin;
  logic                   dim_pin;
  logic                   slo;
  logic                   lso;
  logic [31:0]            s;
  int                     num_errors = 0;
  int                     n_checks = 0;
  int                     cyc = 0;

  always #5 hclk = ~hclk;

  lfdc_pin_driver i_lfdc_pin_driver (.hclk(hclk), .en_target(en_t), .dim_target(dim_t),
    .main_channel_enable(en_pin), .dimming_input(dim_pin));

  lfdc_top #(.DEBOUNCE_CYCLES(DEB), .PWM_TICK_CYCLES(1)) i_lfdc_top (.hclk(hclk), .hresetn(hresetn),
    .ce(ce_t), .ahb_req({m[71:1], hreadyout}), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .main_channel_enable(en_pin), .dimming_input(dim_pin), .switch_light_enable(sle),
    .dimming_source_strap(straps[2]), .enable_style_strap(straps[1]), .dimming_polarity_strap(straps[0]),
    .main_led_outputs(mlo), .switch_light_output(slo), .logic_supply_output(lso));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    m.hsel   <= 1'b1;
    m.haddr  <= a;
    m.htrans <= 2'b10;
    m.hwrite <= wr;
    m.hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    m.hsel   <= 1'b0;
    m.htrans <= 2'b00;
    m.hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    s = hrdata;
  endtask

  task automatic wait_lvl(input int ch, input logic [5:0] v, output int took);
    int t0;
    t0 = cyc;
    do bus(1'b0, lfdc_pkg::STAT_OFS, '0); while (s[ch*8 +: 6] !== v && cyc - t0 < 20000);
    took = cyc - t0;
  endtask

  task automatic do_reset(input logic [2:0] st);
    hresetn <= 1'b0;
    straps  <= st;
    en_t    <= {2{st[1]}};
    dim_t   <= ~st[0];
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (DEB + 20) @(posedge hclk);
  endtask

  task automatic press(input logic [1:0] msk, input int len);
    en_t <= en_t ^ msk;
    repeat (len) @(posedge hclk);
    en_t <= en_t ^ msk;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    do_reset(3'b011);
    chk(mlo, 2'b00);
    chk({hresp, lso}, 2'b01);
    bus(1'b0, lfdc_pkg::FALL_OFS, '0);
    chk(s, 32'h0000_0f80);
    bus(1'b1, 32'h0000_000c, 32'hffff_ffff);
    bus(1'b0, 32'h0000_000c, '0);
    chk(s, '0);
    bus(1'b1, lfdc_pkg::STAT_OFS, 32'hffff_ffff);
    bus(1'b0, lfdc_pkg::STAT_OFS, '0);
    chk(s, 32'h0680_0000);
    bus(1'b1, lfdc_pkg::RISE_OFS, 32'h1);
    bus(1'b1, lfdc_pkg::FALL_OFS, 32'h2);
    bus(1'b0, lfdc_pkg::RISE_OFS, '0);
    chk(s, 32'h1);
    $display("t_regs done");
  endtask

  task automatic t_pulse;
    int took;
    int l0;
    press(2'b01, 15);
    repeat (40) @(posedge hclk);
    bus(1'b0, lfdc_pkg::STAT_OFS, '0);
    chk(s[17:0], '0);
    press(2'b01, 45);
    wait_lvl(0, 6'd62, took);
    chk(took >= 5950 && took <= 6450, 1'b1);
    repeat (3) @(posedge hclk);
    chk({s[13:8], mlo}, {6'd0, 2'b01});
    press(2'b01, 45);
    wait_lvl(0, 6'd0, took);
    chk(took >= 12100 && took <= 12700, 1'b1);
    press(2'b10, 45);
    repeat (2000) @(posedge hclk);
    press(2'b10, 45);
    bus(1'b0, lfdc_pkg::STAT_OFS, '0);
    l0 = s[13:8];
    repeat (600) @(posedge hclk);
    bus(1'b0, lfdc_pkg::STAT_OFS, '0);
    chk(s[13:8] < l0 && l0 < 40 && s[17] === 1'b0, 1'b1);
    wait_lvl(1, 6'd0, took);
    chk(mlo, 2'b00);
    $display("t_pulse done");
  endtask

  task automatic t_level;
    int took;
    do_reset(3'b001);
    bus(1'b1, lfdc_pkg::RISE_OFS, '0);
    bus(1'b1, lfdc_pkg::FALL_OFS, '0);
    en_t <= 2'b01;
    wait_lvl(0, 6'd62, took);
    chk(took >= 6750 && took <= 7250, 1'b1);
    en_t <= 2'b11;
    wait_lvl(1, 6'd62, took);
    chk(s[5:0], 6'd62);
    en_t <= 2'b10;
    wait_lvl(0, 6'd0, took);
    chk({s[13:8], s[17:16], s[23]}, {6'd62, 2'b10, 1'b0});
    $display("t_level done");
  endtask

  task automatic t_direct;
    int took;
    do_reset(3'b111);
    bus(1'b1, lfdc_pkg::RISE_OFS, 32'h1);
    dim_t <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(mlo, 2'b11);
    dim_t <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(mlo, 2'b00);
    press(2'b01, 45);
    wait_lvl(0, 6'd62, took);
    chk(s[26:23], 4'b1111);
    dim_t <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(mlo, 2'b11);
    dim_t <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(mlo, 2'b01);
    do_reset(3'b110);
    dim_t <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(mlo, 2'b11);
    dim_t <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(mlo, 2'b00);
    $display("t_direct done");
  endtask

  task automatic t_internal;
    int took;
    int h0;
    int h1;
    int l;
    do_reset(3'b010);
    bus(1'b1, lfdc_pkg::RISE_OFS, 32'h14);
    bus(1'b1, lfdc_pkg::FALL_OFS, 32'h1);
    dim_t <= 1'b0;
    repeat (10) @(posedge hclk);
    dim_t <= 1'b1;
    repeat (40) @(posedge hclk);
    bus(1'b0, lfdc_pkg::STAT_OFS, '0);
    chk(s[19:0], '0);
    dim_t <= 1'b0;
    wait_lvl(0, 6'd3, took);
    l = s[5:0];
    h0 = 0;
    h1 = 0;
    repeat (1000) begin
      @(posedge hclk);
      h0 += mlo[0];
      h1 += mlo[1];
    end
    chk(h0, lfdc_pkg::GAMMA[l]);
    chk(h1, lfdc_pkg::GAMMA[l]);
    ce_t <= 1'b0;
    repeat (3000) @(posedge hclk);
    ce_t <= 1'b1;
    bus(1'b0, lfdc_pkg::STAT_OFS, '0);
    chk(s[5:0], l[5:0]);
    bus(1'b1, lfdc_pkg::RISE_OFS, 32'h1);
    wait_lvl(1, 6'd62, took);
    chk({s[5:0], s[19:16]}, {6'd62, 4'b1100});
    dim_t <= 1'b1;
    wait_lvl(0, 6'd0, took);
    chk({s[13:8], s[19:16]}, '0);
    chk(took >= 5950 && took <= 6450, 1'b1);
    $display("t_internal done");
  endtask

  task automatic t_switch;
    logic d1;
    logic d2;
    d1 = 1'b0;
    d2 = 1'b0;
    for (int i = 0; i < 64; i++) begin
      @(posedge hclk);
      if (i > 1) chk(slo, d2);
      d2 = d1;
      d1 = i[1] ^ i[4];
      sle <= d1;
    end
    $display("t_switch done");
  endtask

  // ==========================================================================
  // Verdict and timeout
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    t_regs();
    t_pulse();
    t_level();
    t_direct();
    t_internal();
    t_switch();
    wrap_up();
  end
endmodule
